// ===== core/acq_scan_defines.svh
// Offsets, field positions, codes and reset values of the scan control block
`ifndef ACQ_SCAN_DEFINES_SVH
`define ACQ_SCAN_DEFINES_SVH

// ---------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------
`define ACS_ADDR           8'h13
`define ACS_RESET          16'h0000

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define ACS_DONE_BIT       15
`define ACS_TIMEOUT_BIT    14
`define ACS_XFER_BIT       13
`define ACS_RSVD_HI        12
`define ACS_RSVD_LO        11
`define ACS_TEST_HI        10
`define ACS_TEST_LO        8
`define ACS_POLARITY_BIT   7
`define ACS_OVS_HI         6
`define ACS_OVS_LO         4
`define ACS_LOW_HI         7
`define ACS_LOW_LO         0

// ---------------------------------------------------------------------
// Balance-switch test codes
// ---------------------------------------------------------------------
`define ACS_TEST_NONE0     3'h0
`define ACS_TEST_SW_SHORT  3'h1
`define ACS_TEST_SW_OPEN   3'h2
`define ACS_TEST_NONE3     3'h3
`define ACS_TEST_NONE4     3'h4
`define ACS_TEST_OPEN_ODD  3'h5
`define ACS_TEST_OPEN_EVEN 3'h6
`define ACS_TEST_NONE7     3'h7

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define ACS_TIMEOUT_BASE   32'd8192
`define ACS_CNT_W          24

`endif

// ===== core/acq_scan_pkg.sv
// Types shared by the scan control block
package acq_scan_pkg;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SCAN
  } scan_state_e;

  typedef struct packed {
    logic [11:0] bal_sw;
    logic [15:0] measure;
    logic        alt_mux;
    logic        polarity;
  } meas_cfg_s;

  typedef struct packed {
    logic        valid;
    logic [3:0]  chan;
    logic [15:0] data;
  } result_s;

  typedef struct packed {
    logic        short_test;
    logic        open_test;
    logic        sense_odd;
    logic        sense_even;
  } test_mode_s;

endpackage : acq_scan_pkg

// ===== core/acquisition_scan_control.sv
// Scan control and status register with watchdog and switch test modes
// Flags are set by hardware and cleared by writing zero to them; when a
// set and a clear meet in one cycle the flag stays set. The watchdog
// limit doubles with each oversampling step, so a scan with more
// oversamples may run longer before it is flagged as overdue.
`timescale 1ns/1ps
`default_nettype none
`include "acq_scan_defines.svh"

module acquisition_scan_control
  import acq_scan_pkg::*;
#(
  parameter int unsigned TIMEOUT_BASE = `ACS_TIMEOUT_BASE
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Register interface
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output var  logic [15:0] reg_rdata,
  output var  logic        reg_rvalid,
  // Configuration from other registers
  input  wire logic        acquisition_watchdog_enable,
  input  wire meas_cfg_s   cfg_in,
  input  wire logic [15:0] balance_high_threshold,
  input  wire logic [15:0] balance_low_threshold,
  // Acquisition engine
  input  wire logic        scan_request,
  input  wire logic        scan_finish,
  input  wire logic        results_transfer,
  input  wire result_s     result_in,
  output var  logic        scan_start,
  output var  logic        scan_busy,
  output var  logic        data_load,
  output var  logic [2:0]  oversample_sel,
  output var  meas_cfg_s   cfg_eff,
  output var  test_mode_s  test_mode,
  // Status
  output var  logic [11:0] balance_switch_alert_register
);

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  typedef struct packed {
    // Sequencing
    scan_state_e        state;
    logic [`ACS_CNT_W-1:0] cnt;
    // Software-visible fields
    logic               done;
    logic               timeout;
    logic               xfer;
    logic [2:0]         test_sel;
    logic [7:0]         low_bits;
    // Registered outputs
    logic               start;
    logic               load;
    logic [15:0]        rdata;
    logic               rvalid;
    meas_cfg_s          cfg;
    test_mode_s         mode;
    logic [11:0]        alert;
  } state_s;

  state_s q;
  state_s d;

  localparam logic [`ACS_CNT_W-1:0] BASE_CNT = `ACS_CNT_W'(TIMEOUT_BASE);
  localparam logic [15:0]           RST_WORD = `ACS_RESET;

  // Helper terms
  logic                  wr_hit;
  logic                  rd_hit;
  logic                  test_on;
  test_mode_s            mode_dec;
  logic [`ACS_CNT_W-1:0] limit;
  logic                  cnt_expired;
  logic [15:0]           status_word;
  logic                  clr_done;
  logic                  clr_timeout;
  logic                  clr_xfer;
  logic                  set_done;
  logic                  set_timeout;
  logic                  set_xfer;
  logic [11:0]           alert_sel;
  logic [11:0]           alert_hit;

  // -------------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------------
  always_comb begin
    wr_hit = reg_wr && (reg_addr == `ACS_ADDR);
    rd_hit = reg_rd && (reg_addr == `ACS_ADDR);
  end

  // -------------------------------------------------------------------
  // Test select decode
  // -------------------------------------------------------------------
  always_comb begin
    mode_dec = '0;
    // Only the two switch codes and the two sense codes start a test
    case (q.test_sel)
      `ACS_TEST_SW_SHORT:  mode_dec.short_test = 1'b1;
      `ACS_TEST_SW_OPEN:   mode_dec.open_test  = 1'b1;
      `ACS_TEST_OPEN_ODD:  mode_dec.sense_odd  = 1'b1;
      `ACS_TEST_OPEN_EVEN: mode_dec.sense_even = 1'b1;
      `ACS_TEST_NONE0:     mode_dec = '0;
      `ACS_TEST_NONE3:     mode_dec = '0;
      `ACS_TEST_NONE4:     mode_dec = '0;
      `ACS_TEST_NONE7:     mode_dec = '0;
      default:             mode_dec = '0;
    endcase
    test_on = |mode_dec;
  end

  // -------------------------------------------------------------------
  // Watchdog limit
  // -------------------------------------------------------------------
  always_comb begin
    // Allowed duration doubles per oversampling step
    limit       = BASE_CNT << q.low_bits[`ACS_OVS_HI:`ACS_OVS_LO];
    // Counter starts at zero on the first scan cycle
    cnt_expired = (q.cnt >= limit - 1'b1);
  end

  // -------------------------------------------------------------------
  // Flag set and clear terms
  // -------------------------------------------------------------------
  always_comb begin
    // A written zero clears a flag, a written one leaves it
    clr_done    = wr_hit && !reg_wdata[`ACS_DONE_BIT];
    clr_timeout = wr_hit && !reg_wdata[`ACS_TIMEOUT_BIT];
    clr_xfer    = wr_hit && !reg_wdata[`ACS_XFER_BIT];
    set_done    = (q.state == ST_SCAN) && scan_finish;
    // Supervision runs only while the watchdog input is low
    set_timeout = (q.state == ST_SCAN) && !scan_finish &&
                  !acquisition_watchdog_enable && cnt_expired;
    set_xfer    = results_transfer;
  end

  // -------------------------------------------------------------------
  // Status word
  // -------------------------------------------------------------------
  always_comb begin
    // Reserved bits stay zero
    status_word = '0;
    status_word[`ACS_DONE_BIT]    = q.done;
    status_word[`ACS_TIMEOUT_BIT] = q.timeout;
    status_word[`ACS_XFER_BIT]    = q.xfer;
    status_word[`ACS_TEST_HI:`ACS_TEST_LO] = q.test_sel;
    status_word[`ACS_LOW_HI:`ACS_LOW_LO]   = q.low_bits;
  end

  // -------------------------------------------------------------------
  // Per-channel switch alert compare
  // -------------------------------------------------------------------
  for (genvar i = 0; i < 12; i++) begin : g_alert
    // A result only updates the alert of its own channel
    assign alert_sel[i] = result_in.valid && (result_in.chan == 4'(i));
    assign alert_hit[i] = (result_in.data > balance_high_threshold) ||
                          (result_in.data < balance_low_threshold);
  end

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb begin
    d       = q;
    // Pulses last one cycle unless raised again
    d.start = 1'b0;
    d.load  = 1'b0;
    d.rvalid = reg_rd;
    if (reg_rd) begin
      // Unmapped addresses read as zero
      d.rdata = rd_hit ? status_word : 16'h0000;
    end

    // Register write: test select and low byte are plain storage
    if (wr_hit) begin
      d.test_sel = reg_wdata[`ACS_TEST_HI:`ACS_TEST_LO];
      d.low_bits = reg_wdata[`ACS_LOW_HI:`ACS_LOW_LO];
    end

    // Scan sequencing; hardware sets win over a same-cycle clear
    case (q.state)
      ST_IDLE: begin
        d.cnt = '0;
        // A pending complete flag blocks the next scan
        if (scan_request && !q.done) begin
          d.state = ST_SCAN;
          d.start = 1'b1;
          // Alerts start afresh for each test scan
          if (test_on) begin
            d.alert = '0;
          end
        end
      end
      ST_SCAN: begin
        if (scan_finish || set_timeout) begin
          d.state = ST_IDLE;
        end else if (!acquisition_watchdog_enable) begin
          // The counter freezes while the watchdog input is high
          d.cnt = q.cnt + 1'b1;
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase

    // Results move to the data registers all at once
    if (results_transfer) begin
      d.load = 1'b1;
    end

    // Flags: a zero write clears, a same-cycle hardware set wins
    if (set_done) begin
      d.done = 1'b1;
    end else if (clr_done) begin
      d.done = 1'b0;
    end

    if (set_timeout) begin
      d.timeout = 1'b1;
    end else if (clr_timeout) begin
      d.timeout = 1'b0;
    end

    if (set_xfer) begin
      d.xfer = 1'b1;
    end else if (clr_xfer) begin
      d.xfer = 1'b0;
    end

    // Test mode overrides user configuration during acquisition
    if (test_on && q.state == ST_SCAN) begin
      d.cfg.bal_sw   = '0;
      d.cfg.measure  = '0;
      d.cfg.alt_mux  = 1'b0;
      d.cfg.polarity = 1'b0;
    end else begin
      d.cfg = cfg_in;
    end
    d.mode = mode_dec;

    // Switch alerts from each result outside the threshold window
    if (test_on) begin
      d.alert = (d.alert & ~alert_sel) | (alert_hit & alert_sel);
    end

    // Synchronous reset returns every field to its reset value
    if (!rstn) begin
      d          = '0;
      d.state    = ST_IDLE;
      d.done     = RST_WORD[`ACS_DONE_BIT];
      d.timeout  = RST_WORD[`ACS_TIMEOUT_BIT];
      d.xfer     = RST_WORD[`ACS_XFER_BIT];
      d.test_sel = RST_WORD[`ACS_TEST_HI:`ACS_TEST_LO];
      d.low_bits = RST_WORD[`ACS_LOW_HI:`ACS_LOW_LO];
    end
  end

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    q <= d;
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  always_comb begin
    // Every output except scan_busy, which is decoded from the state, is a plain register field
    reg_rdata      = q.rdata;
    reg_rvalid     = q.rvalid;
    scan_start     = q.start;
    scan_busy      = (q.state == ST_SCAN);
    data_load      = q.load;
    oversample_sel = q.low_bits[`ACS_OVS_HI:`ACS_OVS_LO];
    cfg_eff        = q.cfg;
    test_mode      = q.mode;
    balance_switch_alert_register = q.alert;
  end

endmodule : acquisition_scan_control
`default_nettype wire

// ===== tb/acq_scan_props.sv
// Assertions on the ports of the scan control block
`timescale 1ns/1ps
`default_nettype none
module acq_scan_props #(
  parameter int unsigned TIMEOUT_BASE = 16
) (
  // Clock and register bus
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  // Acquisition engine
  input wire logic        scan_request,
  input wire logic        scan_finish,
  input wire logic        results_transfer,
  input wire logic        scan_start,
  input wire logic        scan_busy,
  input wire logic        data_load,
  input wire logic [2:0]  oversample_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_start; scan_start |-> $past(scan_request) && !$past(scan_busy); endproperty
  a_start: assert property (p_start) else $error("start without request");
  property p_pulse; scan_start |=> !scan_start; endproperty
  a_pulse: assert property (p_pulse) else $error("start too long");
  property p_fin; scan_busy && scan_finish |=> !scan_busy; endproperty
  a_fin: assert property (p_fin) else $error("busy after finish");
  property p_load; results_transfer |=> data_load; endproperty
  a_load: assert property (p_load) else $error("no data load");
  property p_loadc; data_load |-> $past(results_transfer); endproperty
  a_loadc: assert property (p_loadc) else $error("load without cause");
  property p_rv; reg_rvalid == $past(reg_rd); endproperty
  a_rv: assert property (p_rv) else $error("read answer wrong");
  property p_rsv; reg_rvalid |-> reg_rdata[12:11] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_osel;
    reg_wr && reg_addr == 8'h13 |=> oversample_sel == $past(reg_wdata[6:4]);
  endproperty
  a_osel: assert property (p_osel) else $error("oversample stale");
  c_start: cover property (scan_start);
  c_load: cover property (data_load);
  c_done: cover property (reg_rvalid && reg_rdata[15]);
endmodule : acq_scan_props
bind acquisition_scan_control acq_scan_props #(.TIMEOUT_BASE(TIMEOUT_BASE))
  i_props (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .scan_request(scan_request),
  .scan_finish(scan_finish), .results_transfer(results_transfer),
  .scan_start(scan_start), .scan_busy(scan_busy), .data_load(data_load),
  .oversample_sel(oversample_sel));
`default_nettype wire

// ===== tb/acquisition_scan_control_tb_top.sv
// Self-checking testbench of the scan control block
`timescale 1ns/1ps
`default_nettype none
module acquisition_scan_control_tb_top
  import acq_scan_pkg::*;
;
  logic        clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        wd_en = 1'b0, scan_request = 1'b0, scan_finish = 1'b0;
  logic        xfer = 1'b0, reg_rvalid, scan_start, scan_busy, data_load;
  logic [7:0]  reg_addr = 8'h13;
  logic [15:0] reg_wdata = 16'h0000, hi = 16'h0800, lo = 16'h0100;
  logic [15:0] reg_rdata, rdata;
  logic [11:0] alerts;
  logic [2:0]  oversample_sel;
  meas_cfg_s   cfg_in = '1, cfg_eff;
  result_s     result_in = '0;
  test_mode_s  test_mode;
  int          bad_count = 0, cmp_count = 0;

  always #20 clk = ~clk;

  acquisition_scan_control #(.TIMEOUT_BASE(16)) i_dut (
    .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .acquisition_watchdog_enable(wd_en),
    .cfg_in(cfg_in), .balance_high_threshold(hi),
    .balance_low_threshold(lo), .scan_request(scan_request),
    .scan_finish(scan_finish), .results_transfer(xfer),
    .result_in(result_in), .scan_start(scan_start),
    .scan_busy(scan_busy), .data_load(data_load),
    .oversample_sel(oversample_sel), .cfg_eff(cfg_eff),
    .test_mode(test_mode), .balance_switch_alert_register(alerts));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // One bus cycle; a read is checked for its answer one cycle later
  task automatic bus(logic w, logic [7:0] a, logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    if (!w) begin
      chk("rvalid", {15'h0, reg_rvalid}, 16'h0001);
      rdata = reg_rdata;
    end
  endtask : bus

  task automatic rchk(logic [7:0] a, logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    chk("register", rdata, exp);
  endtask : rchk

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse

  task automatic wbusy(logic v, int n);
    while (scan_busy !== v) begin
      if (n-- == 0) begin
        bad_count++;
        stop_test();
      end
      @(negedge clk);
    end
  endtask : wbusy

  task automatic t_done;
    pulse(scan_request);
    chk("start", {15'h0, scan_start}, 16'h0001);
    cyc(3);
    pulse(scan_finish);
    cyc(1);
    rchk(8'h13, 16'h8000);
    pulse(scan_request);
    chk("blocked", {15'h0, scan_busy}, 16'h0000);
    bus(1'b1, 8'h13, 16'hf845);
    rchk(8'h13, 16'h8045);
    bus(1'b1, 8'h12, 16'h0000);
    rchk(8'h12, 16'h0000);
    rchk(8'h13, 16'h8045);
    bus(1'b1, 8'h13, 16'h0010);
    rchk(8'h13, 16'h0010);
  endtask : t_done

  task automatic t_timeout;
    pulse(scan_request);
    cyc(20);
    chk("long scan", {15'h0, scan_busy}, 16'h0001);
    wbusy(1'b0, 20);
    rchk(8'h13, 16'h4010);
    bus(1'b1, 8'h13, 16'h4010);
    rchk(8'h13, 16'h4010);
    bus(1'b1, 8'h13, 16'h0010);
    rchk(8'h13, 16'h0010);
    wd_en = 1'b1;
    pulse(scan_request);
    cyc(60);
    chk("no watchdog", {15'h0, scan_busy}, 16'h0001);
    pulse(scan_finish);
    wd_en = 1'b0;
    bus(1'b1, 8'h13, 16'h0000);
  endtask : t_timeout

  task automatic t_xfer;
    pulse(xfer);
    chk("load", {15'h0, data_load}, 16'h0001);
    rchk(8'h13, 16'h2000);
    bus(1'b1, 8'h13, 16'h2000);
    rchk(8'h13, 16'h2000);
    bus(1'b1, 8'h13, 16'h0000);
    rchk(8'h13, 16'h0000);
  endtask : t_xfer

  task automatic t_modes;
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 8'h13, {5'h0, c[2:0], 8'h00});
      rchk(8'h13, {5'h0, c[2:0], 8'h00});
      chk("mode", {12'h0, test_mode},
          {12'h0, c == 1, c == 2, c == 5, c == 6});
    end
    bus(1'b1, 8'h13, 16'h0100);
    pulse(scan_request);
    cyc(1);
    chk("override", {15'h0, cfg_eff === '0}, 16'h0001);
    result_in = '{1'b1, 4'h3, 16'h0900};
    @(negedge clk);
    result_in = '{1'b1, 4'h4, 16'h0050};
    @(negedge clk);
    result_in = '0;
    @(negedge clk);
    chk("alert", {4'h0, alerts}, 16'h0018);
    pulse(scan_finish);
  endtask : t_modes

  initial begin
    cyc(16);
    rstn = 1'b1;
    rchk(8'h13, 16'h0000);
    t_done();
    t_timeout();
    t_xfer();
    t_modes();
    stop_test();
  end
endmodule : acquisition_scan_control_tb_top
`default_nettype wire
